// ### hrp_pkg.sv
package hrp_pkg;

    // Clocking and the derived core rate.
    localparam int CLK_PERIOD_NS   = 4;
    localparam int CORE_DIV        = 2;
    localparam int CORE_SYNC_CYC   = 4;
    localparam int SETTLE_CLKS     = CORE_SYNC_CYC * CORE_DIV;
    localparam int WR_HIGH_NS      = 8;
    localparam int WR_LOW_NS       = 8;
    localparam int WR_HIGH_CLKS    = (WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_LOW_CLKS     = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_SETTLE_CLKS  = 3;

    // Host port addresses.
    localparam logic [2:0] PA_STAGE_LAST = 3'h3;
    localparam logic [2:0] PA_DOWNLOAD   = 3'h4;
    localparam logic [2:0] PA_RB_ADDR    = 3'h6;
    localparam logic [2:0] PA_RB_STEP    = 3'h7;

    // Download codes written to the download address.
    localparam logic [7:0] DL_CTRL       = 8'h00;
    localparam logic [7:0] DL_MEM_UPDATE = 8'h0f;

    // Memory access control word, offset 0x0.
    localparam logic [7:0] CTL_OFFSET    = 8'h00;
    localparam logic [7:0] CTL_RESET     = 8'h00;
    localparam int         CTL_AUTO_BIT  = 6;
    localparam int         CTL_RW_BIT    = 5;
    localparam int         CTL_SEL_LO    = 2;
    localparam int         CTL_WSEL_LO   = 0;

    // Memory select codes.
    localparam logic [2:0] SEL_NONE  = 3'h0;
    localparam logic [2:0] SEL_I     = 3'h1;
    localparam logic [2:0] SEL_Q     = 3'h2;
    localparam logic [2:0] SEL_IQ    = 3'h3;
    localparam logic [2:0] SEL_CONST = 3'h4;
    localparam logic [2:0] SEL_FIFO  = 3'h5;

    // Memory geometry and readback lengths.
    localparam int COEF_DEPTH  = 64;
    localparam int COEF_WIDTH  = 72;
    localparam int CONST_DEPTH = 256;
    localparam int FIFO_DEPTH  = 256;
    localparam int FIFO_WIDTH  = 32;
    localparam logic [3:0] BYTES_COEF  = 4'h9;
    localparam logic [3:0] BYTES_CONST = 4'h1;
    localparam logic [3:0] BYTES_FIFO  = 4'h4;
    localparam logic [1:0] WSEL_LAST   = 2'h2;

    // Host controller registers on AHB-Lite.
    localparam logic [3:0] HR_CMD     = 4'h0;
    localparam logic [3:0] HR_STATUS  = 4'h4;
    localparam int         CMD_RD_BIT = 16;
    localparam int         CMD_STEP_BIT = 17;

endpackage : hrp_pkg

// ### hrp_if.sv
`timescale 1ns/1ps
interface hrp_if;
    logic       ce_n;
    logic       rd_n;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] host_d_o;
    logic       host_d_oe;
    logic [7:0] dev_d_o;
    logic       dev_d_oe;
    logic [7:0] host_data_bus;

    // The device wins the shared bus whenever it drives; an undriven bus reads zero.
    assign host_data_bus = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'h00);

    modport host   (output ce_n, rd_n, wr, addr, host_d_o, host_d_oe, input host_data_bus);
    modport device (input ce_n, rd_n, wr, addr, host_data_bus, output dev_d_o, dev_d_oe);
endinterface : hrp_if

// ### hrp_device.sv
`timescale 1ns/1ps
// Behaviour
// - bit 6 chooses manual or auto addressing
// - bit 5 chooses RAM write or read
// - bits 4:2 select which RAM
// - host clears word select before loading
// - every RAM reachable, FIFO only readable
// - writing 0x0F to address 4 updates buffer
// - host sends three 24-bit slices per word
// - update strobe steps counter, routes slice
// - counter at 2 writes 72-bit word
// - manual address taken from staging bits 31:24
// - control word write zeroes auto address
// - constellation write uses staging bits 23:16
// - readback lengths 9, 1 and 4 bytes
// - address 6 sets readback address, clears count
// - address 7 write steps readback byte count
// - bus shows byte k of addressed word
// - host downloads control byte with 0x00
// - addresses 0 to 3 load staging bytes
// - write strobe edge captures all port writes
// - chip enable gates access, read enables drivers
// - host waits four core cycles after download
module hrp_device
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Host port
    hrp_if.device                         bus,
    // Core side
    input  wire logic                     fifo_wr_en,
    input  wire logic [7:0]               fifo_wr_addr,
    input  wire logic [31:0]              fifo_wr_data,
    input  wire logic [7:0]               const_rd_addr,
    output logic      [7:0]               const_rd_data,
    output logic      [7:0]               memory_access_control,
    output logic      [7:0]               ram_target_address
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]  ctl_r;
    logic [31:0] staging_word_r;
    logic        wr_q_r;
    logic        core_en_r;
    logic        dl_pend_r;
    logic [7:0]  dl_code_r;
    logic [71:0] ram_word_buffer_r;
    logic [7:0]  auto_addr_r;
    logic [7:0]  tgt_addr_r;
    logic [7:0]  ram_readback_address_r;
    logic [3:0]  rb_cnt_r;
    logic [7:0]  dev_d_r;
    logic [7:0]  const_rd_r;

    localparam int COEF_WIDTH_L = hrp_pkg::COEF_WIDTH;

    logic [COEF_WIDTH_L-1:0] coef_i_mem [hrp_pkg::COEF_DEPTH];
    logic [COEF_WIDTH_L-1:0] coef_q_mem [hrp_pkg::COEF_DEPTH];
    logic [7:0]              const_mem  [hrp_pkg::CONST_DEPTH];
    logic [31:0]             fifo_mem   [hrp_pkg::FIFO_DEPTH];

    logic        wr_edge;
    logic        wr_evt;
    logic        step_evt;
    logic        dl_fire;
    logic        ctrl_fire;
    logic        upd_fire;
    logic [2:0]  sel;
    logic [1:0]  wsel;
    logic        is_write;
    logic        sel_coef;
    logic        final_wr;
    logic [7:0]  wr_addr;
    logic [71:0] rb_word;
    logic [3:0]  rb_len;
    logic [7:0]  rb_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // Port write decode. The strobe pin is sampled and its rising edge acts as the port clock.
    assign wr_edge  = bus.wr & ~wr_q_r;
    assign wr_evt   = wr_edge & ~bus.ce_n & bus.rd_n;
    // Stepping happens while reading, so it ignores the read pin.
    assign step_evt = wr_edge & ~bus.ce_n & (bus.addr == hrp_pkg::PA_RB_STEP);

    assign sel      = ctl_r[hrp_pkg::CTL_SEL_LO +: 3];
    assign wsel     = ctl_r[hrp_pkg::CTL_WSEL_LO +: 2];
    assign is_write = ~ctl_r[hrp_pkg::CTL_RW_BIT];
    assign sel_coef = (sel == hrp_pkg::SEL_I) | (sel == hrp_pkg::SEL_Q)
                    | (sel == hrp_pkg::SEL_IQ);

    assign dl_fire   = dl_pend_r & core_en_r;
    assign ctrl_fire = dl_fire & (dl_code_r == hrp_pkg::DL_CTRL);
    assign upd_fire  = dl_fire & (dl_code_r == hrp_pkg::DL_MEM_UPDATE);

    assign final_wr = upd_fire & is_write
                    & ((sel_coef & (wsel == hrp_pkg::WSEL_LAST))
                    | ((sel == hrp_pkg::SEL_CONST) & (wsel == 2'h0)));
    // Manual mode takes the target from the top staging byte.
    assign wr_addr  = ctl_r[hrp_pkg::CTL_AUTO_BIT] ? auto_addr_r
                    : staging_word_r[31:24];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wr_q_r <= 1'b0;
        else
            wr_q_r <= bus.wr;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            staging_word_r <= 32'h0000_0000;
        else if (wr_evt && bus.addr <= hrp_pkg::PA_STAGE_LAST)
            staging_word_r[8*bus.addr[1:0] +: 8] <= bus.host_data_bus;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain at half rate. Downloads wait for the next core enable; the host
    // spacing keeps the staging word stable until then.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            core_en_r <= 1'b0;
        else
            core_en_r <= ~core_en_r;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dl_pend_r <= 1'b0;
            dl_code_r <= 8'h00;
        end
        else if (wr_evt && bus.addr == hrp_pkg::PA_DOWNLOAD)
        begin
            dl_pend_r <= 1'b1;
            dl_code_r <= bus.host_data_bus;
        end
        else if (core_en_r)
            dl_pend_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctl_r <= hrp_pkg::CTL_RESET;
        else if (ctrl_fire)
            ctl_r <= staging_word_r[7:0];
        else if (upd_fire && is_write && sel_coef)
            ctl_r[hrp_pkg::CTL_WSEL_LO +: 2] <= (wsel == hrp_pkg::WSEL_LAST) ? 2'h0
                                              : wsel + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ram_word_buffer_r <= 72'h0;
        else if (upd_fire && is_write && sel_coef)
        begin
            case (wsel)
                2'h0:    ram_word_buffer_r[23:0]  <= staging_word_r[23:0];
                2'h1:    ram_word_buffer_r[47:24] <= staging_word_r[23:0];
                2'h2:    ram_word_buffer_r[71:48] <= staging_word_r[23:0];
                default: ram_word_buffer_r[71:48] <= ram_word_buffer_r[71:48];
            endcase
        end
        else if (upd_fire && is_write && sel == hrp_pkg::SEL_CONST)
            ram_word_buffer_r[71:64] <= staging_word_r[23:16];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            auto_addr_r <= 8'h00;
        else if (ctrl_fire)
            auto_addr_r <= 8'h00;
        else if (final_wr && ctl_r[hrp_pkg::CTL_AUTO_BIT])
            auto_addr_r <= auto_addr_r + 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tgt_addr_r <= 8'h00;
        else if (final_wr)
            tgt_addr_r <= wr_addr;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RAM storage. The FIFO is filled only from the core side.
    always_ff @(posedge clk)
    begin
        if (final_wr && (sel == hrp_pkg::SEL_I || sel == hrp_pkg::SEL_IQ))
            coef_i_mem[wr_addr[5:0]] <= {staging_word_r[23:0], ram_word_buffer_r[47:0]};
        if (final_wr && (sel == hrp_pkg::SEL_Q || sel == hrp_pkg::SEL_IQ))
            coef_q_mem[wr_addr[5:0]] <= {staging_word_r[23:0], ram_word_buffer_r[47:0]};
        if (final_wr && sel == hrp_pkg::SEL_CONST)
            const_mem[wr_addr] <= staging_word_r[23:16];
        if (fifo_wr_en)
            fifo_mem[fifo_wr_addr] <= fifo_wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            const_rd_r <= 8'h00;
        else
            const_rd_r <= const_mem[const_rd_addr];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Readback.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ram_readback_address_r <= 8'h00;
            rb_cnt_r               <= 4'h0;
        end
        else if (wr_evt && bus.addr == hrp_pkg::PA_RB_ADDR)
        begin
            ram_readback_address_r <= bus.host_data_bus;
            rb_cnt_r               <= 4'h0;
        end
        else if (step_evt && rb_cnt_r != 4'hf)
            rb_cnt_r <= rb_cnt_r + 4'h1;
    end

    always_comb
    begin
        rb_word = 72'h0;
        rb_len  = 4'h0;
        case (sel)
            hrp_pkg::SEL_I, hrp_pkg::SEL_IQ:
            begin
                rb_word = coef_i_mem[ram_readback_address_r[5:0]];
                rb_len  = hrp_pkg::BYTES_COEF;
            end
            hrp_pkg::SEL_Q:
            begin
                rb_word = coef_q_mem[ram_readback_address_r[5:0]];
                rb_len  = hrp_pkg::BYTES_COEF;
            end
            hrp_pkg::SEL_CONST:
            begin
                rb_word = {64'h0, const_mem[ram_readback_address_r]};
                rb_len  = hrp_pkg::BYTES_CONST;
            end
            hrp_pkg::SEL_FIFO:
            begin
                rb_word = {40'h0, fifo_mem[ram_readback_address_r]};
                rb_len  = hrp_pkg::BYTES_FIFO;
            end
            default:
            begin
                rb_word = 72'h0;
                rb_len  = 4'h0;
            end
        endcase
        rb_byte = (rb_cnt_r < rb_len) ? rb_word[8*rb_cnt_r +: 8] : 8'h00;
    end

    // Addresses 0 to 3 read the staging bytes back; 4 to 7 read the memory byte.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            dev_d_r <= 8'h00;
        else if (bus.addr[2])
            dev_d_r <= rb_byte;
        else
            dev_d_r <= staging_word_r[8*bus.addr[1:0] +: 8];
    end

    assign bus.dev_d_o           = dev_d_r;
    assign bus.dev_d_oe          = ~bus.ce_n & ~bus.rd_n;
    assign const_rd_data         = const_rd_r;
    assign memory_access_control = ctl_r;
    assign ram_target_address    = tgt_addr_r;

endmodule : hrp_device

// ### hrp_host.sv
`timescale 1ns/1ps
module hrp_host
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Host port
    hrp_if.host              bus
);

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE, ST_RD_WAIT} hrp_st_t;

    ////////////////////////////////////////////////////////////////////////////////
    hrp_st_t     st_r;
    logic [3:0]  tmr_r;
    logic        ap_wr_r;
    logic [3:0]  ap_addr_r;
    logic [31:0] hrdata_r;
    logic [2:0]  p_addr_r;
    logic [7:0]  p_data_r;
    logic        p_rd_r;
    logic        p_step_r;
    logic [7:0]  rd_byte_r;
    logic        cmd_go;

    assign cmd_go = ap_wr_r && ap_addr_r == hrp_pkg::HR_CMD && st_r == ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave with zero wait states. A command written while busy is dropped.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ap_wr_r   <= 1'b0;
            ap_addr_r <= 4'h0;
            hrdata_r  <= 32'h0000_0000;
        end
        else
        begin
            ap_wr_r   <= hsel & hready & htrans[1] & hwrite;
            ap_addr_r <= haddr[3:0];
            if (hsel && hready && htrans[1] && !hwrite && haddr[3:0] == hrp_pkg::HR_STATUS)
                hrdata_r <= {16'h0000, rd_byte_r, 7'h00, st_r != ST_IDLE};
            else
                hrdata_r <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            p_addr_r <= 3'h0;
            p_data_r <= 8'h00;
            p_rd_r   <= 1'b0;
            p_step_r <= 1'b0;
        end
        else if (cmd_go)
        begin
            p_addr_r <= hwdata[10:8];
            p_data_r <= hwdata[7:0];
            p_rd_r   <= hwdata[hrp_pkg::CMD_RD_BIT];
            p_step_r <= hwdata[hrp_pkg::CMD_STEP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port sequencer. The strobe stays at a quarter of the clock rate or slower, and
    // a download is followed by enough idle time for the core side to take it.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r      <= ST_IDLE;
            tmr_r     <= 4'h0;
            rd_byte_r <= 8'h00;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                    if (cmd_go)
                        st_r <= ST_SETUP;
                ST_SETUP:
                begin
                    tmr_r <= (p_rd_r) ? 4'(hrp_pkg::RD_SETTLE_CLKS - 1)
                           : 4'(hrp_pkg::WR_HIGH_CLKS - 1);
                    st_r  <= (p_rd_r) ? ST_RD_WAIT : ST_STROBE;
                end
                ST_RD_WAIT:
                    if (tmr_r == 4'h0)
                    begin
                        rd_byte_r <= bus.host_data_bus;
                        tmr_r     <= 4'(hrp_pkg::WR_HIGH_CLKS - 1);
                        st_r      <= (p_step_r) ? ST_STROBE : ST_IDLE;
                    end
                    else
                        tmr_r <= tmr_r - 4'h1;
                ST_STROBE:
                    if (tmr_r == 4'h0)
                    begin
                        tmr_r <= (p_addr_r == hrp_pkg::PA_DOWNLOAD && !p_rd_r)
                               ? 4'(hrp_pkg::SETTLE_CLKS - 1)
                               : 4'(hrp_pkg::WR_LOW_CLKS - 1);
                        st_r  <= ST_RELEASE;
                    end
                    else
                        tmr_r <= tmr_r - 4'h1;
                ST_RELEASE:
                    if (tmr_r == 4'h0)
                        st_r <= ST_IDLE;
                    else
                        tmr_r <= tmr_r - 4'h1;
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    assign bus.ce_n      = (st_r == ST_IDLE);
    assign bus.rd_n      = ~p_rd_r | (st_r == ST_IDLE);
    assign bus.wr        = (st_r == ST_STROBE);
    assign bus.addr      = p_addr_r;
    assign bus.host_d_o  = p_data_r;
    assign bus.host_d_oe = ~p_rd_r & (st_r != ST_IDLE);
    assign hrdata        = hrdata_r;
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;

endmodule : hrp_host

// ### hrp_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module hrp_checker
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Host port wires
    input wire logic       ce_n,
    input wire logic       rd_n,
    input wire logic       wr,
    input wire logic [2:0] addr,
    input wire logic [7:0] host_d_o,
    input wire logic       host_d_oe,
    input wire logic [7:0] dev_d_o,
    input wire logic       dev_d_oe,
    input wire logic [7:0] host_data_bus
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // One strobe pulse: two cycles high, then low again.
    sequence s_pulse;
        wr [*2] ##1 !wr;
    endsequence

    property p_dev_oe;
        dev_d_oe == (!ce_n && !rd_n);
    endproperty
    a_dev_oe: assert property (p_dev_oe)
        else $error("device bus drive does not follow chip enable and read");

    property p_host_quiet;
        host_d_oe |-> rd_n;
    endproperty
    a_host_quiet: assert property (p_host_quiet)
        else $error("host drives the bus during a read");

    property p_ce_on_wr;
        $rose(wr) |-> !ce_n;
    endproperty
    a_ce_on_wr: assert property (p_ce_on_wr)
        else $error("write strobe without chip enable");

    property p_wr_pulse;
        $rose(wr) |-> s_pulse;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe high time wrong");

    property p_wr_low;
        $fell(wr) |-> !wr [*2];
    endproperty
    a_wr_low: assert property (p_wr_low)
        else $error("write strobe low time too short");

    // A download needs four core cycles, eight clocks, before the next strobe.
    property p_settle;
        $rose(wr) && rd_n && addr == 3'h4 |-> ##2 !wr [*6];
    endproperty
    a_settle: assert property (p_settle)
        else $error("next port write too soon after a download");

    property p_hold;
        $rose(wr) |=> $stable(addr) && $stable(host_d_o) && $stable(ce_n);
    endproperty
    a_hold: assert property (p_hold)
        else $error("address or data moved while the strobe was high");

    property p_wr_data;
        $rose(wr) && rd_n |-> host_d_oe && host_data_bus == host_d_o;
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("port write without host data on the bus");
endmodule : hrp_checker

// ### test_host_ram_access_port.sv
`timescale 1ns/1ps
module test_host_ram_access_port;
    logic        clk           = 1'b0;
    logic        rst_n         = 1'b0;
    logic [31:0] haddr         = 32'h0;
    logic [1:0]  htrans        = 2'h0;
    logic        hwrite        = 1'b0;
    logic [2:0]  hsize         = 3'h2;
    logic [31:0] hwdata        = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        fifo_wr_en    = 1'b0;
    logic [7:0]  fifo_wr_addr  = 8'h00;
    logic [31:0] fifo_wr_data  = 32'h0;
    logic [7:0]  const_rd_addr = 8'h00;
    logic [7:0]  const_rd_data;
    logic [7:0]  memory_access_control;
    logic [7:0]  ram_target_address;
    logic        got_v         = 1'b0;
    logic [7:0]  got_d         = 8'h00;
    logic [8:0]  mon_e;
    logic [8:0]  exp_q[$];
    int          errors        = 0;
    int          total_checks  = 0;

    hrp_if bus_if();
    hrp_host hrp_host_inst(.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .bus(bus_if.host));
    hrp_device hrp_device_inst(.clk(clk), .rst_n(rst_n), .bus(bus_if.device),
        .fifo_wr_en(fifo_wr_en), .fifo_wr_addr(fifo_wr_addr), .fifo_wr_data(fifo_wr_data),
        .const_rd_addr(const_rd_addr), .const_rd_data(const_rd_data),
        .memory_access_control(memory_access_control), .ram_target_address(ram_target_address));
    hrp_checker hrp_checker_inst(.clk(clk), .rst_n(rst_n), .ce_n(bus_if.ce_n),
        .rd_n(bus_if.rd_n), .wr(bus_if.wr), .addr(bus_if.addr), .host_d_o(bus_if.host_d_o),
        .host_d_oe(bus_if.host_d_oe), .dev_d_o(bus_if.dev_d_o), .dev_d_oe(bus_if.dev_d_oe),
        .host_data_bus(bus_if.host_data_bus));

    always #(hrp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic ahb(input logic wr_en, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        haddr  <= a;
        hwrite <= wr_en;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb

    // The sequencer raises busy at the edge that completes the command write, before the two-edge wait and the polling.
    task automatic port(input logic [2:0] a, input logic [7:0] d, input logic rd,
                        input logic stp, output logic [7:0] q);
        logic [31:0] s;
        ahb(1'b1, {28'h0, hrp_pkg::HR_CMD}, {14'h0, stp, rd, 5'h0, a, d}, s);
        repeat (2) @(posedge clk);
        do ahb(1'b0, {28'h0, hrp_pkg::HR_STATUS}, 32'h0, s); while (s[0] !== 1'b0);
        q = s[15:8];
    endtask : port

    task automatic w8(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        port(a, d, 1'b0, 1'b0, q);
    endtask : w8

    task automatic see(input logic k, input logic [7:0] e, input logic [7:0] g);
        exp_q.push_back({k, e});
        got_d <= g;
        got_v <= 1'b1;
        @(posedge clk);
        got_v <= 1'b0;
        @(posedge clk);
    endtask : see

    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: bus byte %h expected %h", $time, g, e);
        end
    endtask : cmp_byte

    task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: device output %h expected %h", $time, g, e);
        end
    endtask : cmp_reg

    task automatic setctl(input logic [7:0] ctl);
        w8(3'h0, ctl);
        w8(3'h4, hrp_pkg::DL_CTRL);
        see(1'b1, ctl, memory_access_control);
    endtask : setctl

    task automatic load_coef(input logic [71:0] w, input logic [7:0] a, input logic man,
                             input logic [7:0] ctl);
        for (int i = 0; i < 3; i++)
        begin
            for (int b = 0; b < 3; b++)
                w8(3'(b), w[24*i+8*b +: 8]);
            if (man && i == 2)
                w8(3'h3, a);
            w8(3'h4, hrp_pkg::DL_MEM_UPDATE);
            see(1'b1, ctl | 8'((i + 1) % 3), memory_access_control);
        end
        see(1'b1, a, ram_target_address);
    endtask : load_coef

    // One byte past the word length is read too; it must come back as zero.
    task automatic read_word(input logic [7:0] ctl, input logic [7:0] a,
                             input logic [71:0] w, input int n);
        logic [7:0] q;
        setctl(ctl);
        w8(3'h6, a);
        for (int k = 0; k <= n; k++)
        begin
            port(3'h7, 8'h00, 1'b1, 1'b1, q);
            see(1'b0, (k < n) ? w[8*k +: 8] : 8'h00, q);
        end
    endtask : read_word

    task results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
        if (got_v === 1'b1 && exp_q.size() > 0)
        begin
            mon_e = exp_q.pop_front();
            if (mon_e[8])
                cmp_reg(mon_e[7:0], got_d);
            else
                cmp_byte(mon_e[7:0], got_d);
        end

    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        results();
    end

    initial
    begin
        logic [7:0]  a;
        logic [7:0]  c;
        logic [7:0]  v;
        logic [7:0]  q;
        logic [71:0] w;
        logic [31:0] d;
        logic [31:0] s;
        void'($urandom(6));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        see(1'b1, hrp_pkg::CTL_RESET, memory_access_control);
        a = 8'($urandom_range(63));
        w = 72'({$urandom(), $urandom(), $urandom()});
        setctl(8'h0c);
        load_coef(w, a, 1'b1, 8'h0c);
        read_word(8'h24, a, w, 9);
        read_word(8'h28, a, w, 9);
        setctl(8'h44);
        load_coef(72'h0, 8'h00, 1'b0, 8'h44);
        load_coef(~w, 8'h01, 1'b0, 8'h44);
        read_word(8'h24, 8'h01, ~w, 9);
        setctl(8'h44);
        load_coef(w, 8'h00, 1'b0, 8'h44);
        v = 8'($urandom());
        c = 8'($urandom());
        setctl(8'h10);
        w8(3'h2, v);
        w8(3'h3, c);
        w8(3'h4, hrp_pkg::DL_MEM_UPDATE);
        see(1'b1, 8'h10, memory_access_control);
        see(1'b1, c, ram_target_address);
        const_rd_addr <= c;
        repeat (2) @(posedge clk);
        see(1'b1, v, const_rd_data);
        read_word(8'h30, c, {64'h0, v}, 1);
        d = $urandom();
        fifo_wr_addr <= c;
        fifo_wr_data <= d;
        fifo_wr_en   <= 1'b1;
        @(posedge clk);
        fifo_wr_en <= 1'b0;
        setctl(8'h14);
        repeat (3) w8(3'h4, hrp_pkg::DL_MEM_UPDATE);
        see(1'b1, 8'h14, memory_access_control);
        read_word(8'h34, c, {40'h0, d}, 4);
        read_word(8'h00, c, 72'h0, 0);
        for (int b = 0; b < 4; b++)
        begin
            w8(3'(b), ~d[8*b +: 8]);
            port(3'(b), 8'h00, 1'b1, 1'b0, q);
            see(1'b0, ~d[8*b +: 8], q);
        end
        ahb(1'b0, 32'h10, 32'h0, s);
        see(1'b0, 8'h00, s[7:0]);
        results();
    end
endmodule : test_host_ram_access_port
